// ==== fault_log_pkg.sv ====
package fault_log_pkg;

	// Circular record layout
	localparam logic [5:0] REC_BYTES = 6'h28;
	localparam logic [5:0] REC_LAST_POS = 6'h27;
	localparam int NUM_REC = 5;
	localparam int NUM_SLOTS = 10;
	localparam logic [3:0] LAST_SLOT = 4'h9;

	// Block byte map
	localparam logic [7:0] BYTE_COUNT = 8'hff;
	localparam logic [7:0] PTR_BYTE = 8'h00;
	localparam logic [7:0] TS_FIRST = 8'h01;
	localparam logic [7:0] TS_LAST = 8'h06;
	localparam logic [7:0] PK_FIRST = 8'h07;
	localparam logic [7:0] PK_LAST = 8'h2e;
	localparam logic [7:0] LOOP_FIRST = 8'h2f;
	localparam logic [7:0] LOOP_LAST = 8'hed;
	localparam logic [7:0] BLOCK_LAST = 8'hfe;
	localparam logic [7:0] PAD_BYTE = 8'h00;
	localparam int LOOP_LEN = 191;

	// Reset values of the tracked extremes
	localparam logic [15:0] PEAK_RESET = 16'h0000;
	localparam logic [15:0] MIN_RESET = 16'hffff;

	// Share-clock timestamp
	localparam int TS_BITS = 41;
	localparam int TICK_US = 200;
	localparam int CLK_MHZ = 50;
	localparam int TICK_CYCLES = TICK_US * CLK_MHZ;

	// Slots in record order; the preamble pairs follow the same order
	typedef enum logic [3:0] {
		SLOT_CH0, SLOT_CH1, SLOT_VIN, SLOT_CH2, SLOT_CH3,
		SLOT_TEMP, SLOT_CH4, SLOT_CH5, SLOT_CH6, SLOT_CH7
	} slot_e;

	typedef enum logic {RD_IDLE, RD_SEND} rd_state_e;

	function automatic logic [5:0] slot_base(input logic [3:0] slot);
		return {slot, 2'b00};
	endfunction

	function automatic logic [7:0] lin_addr(input logic [2:0] rec,
		input logic [5:0] pos);
		return 8'(rec) * 8'(REC_BYTES) + 8'(pos);
	endfunction

endpackage

// ==== peak_min_track.sv ====
module peak_min_track
	import fault_log_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        rst,
	input  wire logic        sample_valid,
	input  wire logic [15:0] sample,
	output logic      [15:0] peak,
	output logic      [15:0] min_value
);

	// Unsigned compare; readings are kept as raw codes
	wire take_peak = sample_valid && (sample > peak);
	wire take_min = sample_valid && (sample < min_value);

	always_ff @(posedge clock) begin
		if (rst) begin
			peak <= PEAK_RESET;
			min_value <= MIN_RESET;
		end else begin
			if (take_peak) begin
				peak <= sample;
			end
			if (take_min) begin
				min_value <= sample;
			end
		end
	end

endmodule

// ==== fault_log_block_readout.sv ====
// What this block does
// - Telemetry buffer is 40-byte records, positions 0..39, 11 and 23 reserved.
// - Positions 0-7 channels 0,1 and 12-19 channels 2,3: vout lo, hi, status, mfr.
// - Positions 24-39 hold channels 4-7, four bytes each, channel 6 at 32.
// - Positions 8,9 hold input voltage lo/hi, position 10 its status.
// - Positions 20,21 hold temperature lo/hi, position 22 its status.
// - Block byte 0 returns the pointer captured at the fault.
// - Bytes 1-6 return 41-bit timestamp, LSB first, bit 40 alone in byte 6.
// - Bytes 7-46 return peak/min pairs low byte first in slot order.
// - Byte 47 returns the buffer byte at the captured pointer.
// - Following bytes step down one position, wrapping 0 to 39 of earlier record.
// - Circular data ends at block byte 237.
// - Bytes 238-254 return zero; the host still reads them.
// - One block read, count byte 0xff first, then the captured pointer.
// - Buffer updates after each measurement only while lock is clear.
module fault_log_block_readout
	import fault_log_pkg::*;
#(
	parameter int TICK_CYCLES_P = fault_log_pkg::TICK_CYCLES,
	parameter int NUM_REC_P = fault_log_pkg::NUM_REC
) (
	input  wire logic        clock,
	input  wire logic        rst,
	input  wire logic        meas_valid,
	input  wire logic [3:0]  meas_slot,
	input  wire logic [15:0] meas_value,
	input  wire logic [7:0]  meas_status,
	input  wire logic [7:0]  meas_mfr,
	input  wire logic        fault_capture,
	input  wire logic        log_clear,
	input  wire logic        rd_start,
	input  wire logic        rd_req,
	output logic      [7:0]  rd_data,
	output logic             rd_valid,
	output logic             rd_busy,
	output logic             buf_locked
);

	// Refused at elaboration: the ring must hold the whole loop
	if (TICK_CYCLES_P < 1) begin : g_bad_tick
		$error("TICK_CYCLES_P must be at least one");
	end
	if (NUM_REC_P * 40 < LOOP_LEN || NUM_REC_P > 6) begin : g_bad_rec
		$error("NUM_REC_P must cover the loop and fit 8-bit addressing");
	end

	localparam int MEM_BYTES = NUM_REC_P * 40;
	localparam logic [2:0] REC_TOP = 3'(NUM_REC_P - 1);

	logic [7:0] mem [MEM_BYTES];
	logic [5:0] wr_pos;
	logic [2:0] wr_rec;
	logic [5:0] cap_pos;
	logic [2:0] cap_rec;
	logic [TS_BITS-1:0] cap_ts;
	logic [TS_BITS-1:0] ts;
	logic [31:0] tick_cnt;
	logic [5:0] rd_pos;
	logic [2:0] rd_rec;
	logic [7:0] idx;
	rd_state_e state;

	// Write side
	wire slot_ok = (meas_slot <= LAST_SLOT);
	// Slots above the last one would write past the record; dropped
	wire meas_take = meas_valid && !buf_locked && slot_ok;
	wire [5:0] wr_base = slot_base(meas_slot);
	wire resv_slot = (meas_slot == SLOT_VIN) || (meas_slot == SLOT_TEMP);
	wire [7:0] fourth_byte = resv_slot ? PAD_BYTE : meas_mfr;
	wire rec_done = (meas_slot == LAST_SLOT);
	wire [2:0] next_wr_rec = (wr_rec == REC_TOP) ? 3'h0 : wr_rec + 3'h1;
	wire [7:0] wr_addr = lin_addr(wr_rec, wr_base);

	always_ff @(posedge clock) begin
		if (meas_take) begin
			mem[wr_addr] <= meas_value[7:0];
			mem[wr_addr + 8'h01] <= meas_value[15:8];
			mem[wr_addr + 8'h02] <= meas_status;
			mem[wr_addr + 8'h03] <= fourth_byte;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			wr_pos <= 6'h00;
			wr_rec <= 3'h0;
		end else if (meas_take) begin
			wr_pos <= wr_base + 6'h03;
			if (rec_done) begin
				wr_rec <= next_wr_rec;
			end
		end
	end

	// Extremes, frozen together with the buffer
	logic [15:0] peak [NUM_SLOTS];
	logic [15:0] min_value [NUM_SLOTS];

	for (genvar s = 0; s < NUM_SLOTS; s++) begin : g_track
		peak_min_track u_track (
			.clock       (clock),
			.rst         (rst),
			.sample_valid(meas_take && (meas_slot == 4'(s))),
			.sample      (meas_value),
			.peak        (peak[s]),
			.min_value   (min_value[s])
		);
	end

	// Share-clock timestamp
	wire tick = (tick_cnt == 32'(TICK_CYCLES_P - 1));

	always_ff @(posedge clock) begin
		if (rst) begin
			tick_cnt <= 32'h0;
			ts <= '0;
		end else begin
			tick_cnt <= tick ? 32'h0 : tick_cnt + 32'h1;
			if (tick) begin
				ts <= ts + 41'h1;
			end
		end
	end

	// Lock: a capture in the clearing cycle still wins
	wire read_end = (state == RD_SEND) && rd_req && (idx == BYTE_COUNT);
	wire lock_clear = read_end || log_clear;
	wire cap_take = fault_capture && (!buf_locked || lock_clear);
	wire next_locked = cap_take || (buf_locked && !lock_clear);

	always_ff @(posedge clock) begin
		if (rst) begin
			buf_locked <= 1'b0;
			cap_pos <= 6'h00;
			cap_rec <= 3'h0;
			cap_ts <= '0;
		end else begin
			buf_locked <= next_locked;
			if (cap_take) begin
				cap_pos <= wr_pos;
				cap_rec <= wr_rec;
				cap_ts <= ts;
			end
		end
	end

	// Read side: idx 0 is the count byte, idx n is block byte n-1
	wire [7:0] blk = idx - 8'h01;
	wire is_count = (idx == 8'h00);
	wire is_ptr = !is_count && (blk == PTR_BYTE);
	wire is_ts = !is_count && (blk >= TS_FIRST) && (blk <= TS_LAST);
	wire is_pk = !is_count && (blk >= PK_FIRST) && (blk <= PK_LAST);
	wire is_loop = !is_count && (blk >= LOOP_FIRST) && (blk <= LOOP_LAST);
	wire [7:0] ts_off = blk - TS_FIRST;
	wire [TS_BITS-1:0] ts_shift = cap_ts >> {ts_off[2:0], 3'b000};
	wire [7:0] ts_sel = ts_shift[7:0];
	wire [7:0] pk_off = blk - PK_FIRST;
	wire [3:0] pk_slot = pk_off[5:2];
	wire [15:0] pk_word = pk_off[1] ? min_value[pk_slot] : peak[pk_slot];
	wire [7:0] pk_sel = pk_off[0] ? pk_word[15:8] : pk_word[7:0];
	wire [7:0] loop_sel = mem[lin_addr(rd_rec, rd_pos)];
	wire [2:0] prev_rec = (rd_rec == 3'h0) ? REC_TOP : rd_rec - 3'h1;

	logic [7:0] next_byte;
	always_comb begin
		if (is_count) begin
			next_byte = BYTE_COUNT;
		end else if (is_ptr) begin
			next_byte = {2'b00, cap_pos};
		end else if (is_ts) begin
			next_byte = ts_sel;
		end else if (is_pk) begin
			next_byte = pk_sel;
		end else if (is_loop) begin
			next_byte = loop_sel;
		end else begin
			next_byte = PAD_BYTE;
		end
	end

	wire send = (state == RD_SEND) && rd_req;

	always_ff @(posedge clock) begin
		if (rst) begin
			state <= RD_IDLE;
			idx <= 8'h00;
			rd_pos <= 6'h00;
			rd_rec <= 3'h0;
			rd_data <= 8'h00;
			rd_valid <= 1'b0;
			rd_busy <= 1'b0;
		end else begin
			rd_valid <= send;
			case (state)
				RD_IDLE: begin
					if (rd_start) begin
						state <= RD_SEND;
						rd_busy <= 1'b1;
						idx <= 8'h00;
						rd_pos <= cap_pos;
						rd_rec <= cap_rec;
					end
				end
				RD_SEND: begin
					if (rd_req) begin
						rd_data <= next_byte;
						idx <= idx + 8'h01;
						if (is_loop) begin
							if (rd_pos == 6'h00) begin
								rd_pos <= REC_LAST_POS;
								rd_rec <= prev_rec;
							end else begin
								rd_pos <= rd_pos - 6'h01;
							end
						end
						if (idx == BYTE_COUNT) begin
							state <= RD_IDLE;
							rd_busy <= 1'b0;
						end
					end
				end
				default: begin
					state <= RD_IDLE;
					rd_busy <= 1'b0;
				end
			endcase
		end
	end

	// Checks
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	// Expected loop position from the pointer, done independently of rd_pos
	wire [7:0] loop_off = blk - LOOP_FIRST;
	wire [8:0] mod_base = 9'(cap_pos) + 9'd200 - 9'(loop_off);
	wire [5:0] expect_pos = 6'(mod_base % 9'd40);

	count_first_a: assert property (
		send && is_count |=> rd_valid && rd_data == 8'hff)
		else $error("count byte not 0xff");
	pointer_byte_a: assert property (
		send && is_ptr |=> rd_data == {2'b00, $past(cap_pos)})
		else $error("block byte 0 not the captured pointer");
	ts_top_a: assert property (
		send && idx == 8'h07 |=> rd_data == {7'h0, $past(cap_ts[40])})
		else $error("timestamp bit 40 misplaced");
	peak_lo_a: assert property (
		send && idx == 8'h08 |=> rd_data == $past(peak[0][7:0]))
		else $error("first peak byte wrong");
	first_loop_a: assert property (
		send && blk == LOOP_FIRST && !is_count
		|-> rd_pos == cap_pos && rd_rec == cap_rec)
		else $error("loop not started at captured pointer");
	loop_pos_a: assert property (
		state == RD_SEND && is_loop |-> rd_pos == expect_pos)
		else $error("loop position not pointer minus offset mod 40");
	wrap_down_a: assert property (
		send && is_loop && rd_pos == 6'h00 |=> rd_pos == 6'd39)
		else $error("no wrap from 0 to 39");
	pad_zero_a: assert property (
		send && !is_count && blk > LOOP_LAST |=> rd_data == 8'h00)
		else $error("padding byte not zero");
	record_pos_a: assert property (
		wr_pos < 6'd40 && rd_pos < 6'd40)
		else $error("position outside record");
	lock_hold_a: assert property (
		buf_locked && meas_valid |=> $stable(wr_pos) && $stable(wr_rec))
		else $error("buffer moved while locked");
	read_unlock_a: assert property (
		read_end && !fault_capture |=> !buf_locked && !rd_busy)
		else $error("full read did not release lock");

	ts_low_a: assert property (
		send && idx == 8'h02 |=> rd_data == $past(cap_ts[7:0]))
		else $error("timestamp low byte wrong");
	min_hi_a: assert property (
		send && idx == 8'h2f |=> rd_data == $past(min_value[9][15:8]))
		else $error("last minimum byte wrong");
	capture_lock_a: assert property (
		fault_capture && (!buf_locked || log_clear) |=> buf_locked)
		else $error("capture did not lock the buffer");
	peak_frozen_a: assert property (
		buf_locked |=> $stable(peak[9]) && $stable(min_value[9]))
		else $error("extremes moved while locked");
	busy_start_a: assert property (
		rd_start && !rd_busy |=> rd_busy)
		else $error("read did not start");
	valid_pulse_a: assert property (
		rd_valid == $past(send))
		else $error("byte not returned one cycle after request");
	last_byte_a: assert property (
		send && idx == BYTE_COUNT |=> rd_data == 8'h00 && !rd_busy)
		else $error("last padding byte wrong or read not ended");
	ch6_slot_a: assert property (
		meas_take && meas_slot == 4'h8 |=> wr_pos == 6'd35)
		else $error("channel 6 not at positions 32 to 35");
	vin_slot_a: assert property (
		meas_take && meas_slot == 4'h2 |=> wr_pos == 6'd11)
		else $error("input voltage not at positions 8 to 11");

	// Main scenarios
	full_read_c: cover property (read_end);
	capture_c: cover property (cap_take ##1 buf_locked);
	wrap_c: cover property (send && is_loop && rd_pos == 6'h00);
	locked_meas_c: cover property (buf_locked && meas_valid);
	padding_c: cover property (send && blk == BLOCK_LAST);

endmodule

// ==== host_reader.sv ====
module host_reader (
	input  wire logic       clock,
	output logic            rd_start,
	output logic            rd_req,
	input  wire logic [7:0] rd_data,
	input  wire logic       rd_valid
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] got [256];
	int         lost;
	initial begin
		rd_start = 1'b0;
		rd_req = 1'b0;
		lost = 0;
	end
	// Count byte plus every block byte, padding too
	task automatic read_block(input int gap);
		@(negedge clock) rd_start = 1'b1;
		@(negedge clock) rd_start = 1'b0;
		for (int i = 0; i < 256; i++) begin
			if (!rd_req) rd_req = 1'b1;
			@(negedge clock);
			if (rd_valid !== 1'b1) lost++;
			got[i] = rd_data;
			if (gap != 0 || i == 255) begin
				rd_req = 1'b0;
				repeat (gap) @(negedge clock);
			end
		end
	endtask
	task automatic stray_req(output logic seen);
		@(negedge clock) rd_req = 1'b1;
		@(negedge clock) rd_req = 1'b0;
		seen = rd_valid;
	endtask
endmodule

// ==== fault_log_block_readout_tb.sv ====
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin \
	num_errors++; $display("unexpected %s exp %h got %h", n, e, g); end end
module fault_log_block_readout_tb;
	import fault_log_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clock, rst, meas_valid, fault_capture, log_clear;
	logic [3:0]  meas_slot;
	logic [15:0] meas_value;
	logic [7:0]  meas_status, meas_mfr, rd_data;
	logic        rd_start, rd_req, rd_valid, rd_busy, buf_locked, seen;
	int          num_errors = 0, num_checks = 0, cyc, wr_rec, ptr;
	int          cap_rec, cap_ptr, cap_cyc;
	logic [31:0] seed = 32'h4e51823f;
	logic [7:0]  mem [200];
	logic [7:0]  exp_b [256];
	logic [15:0] pk [10], mn [10];
	bit          locked;

	fault_log_block_readout #(.TICK_CYCLES_P(4), .NUM_REC_P(5))
		fault_log_block_readout_i (.clock(clock), .rst(rst),
		.meas_valid(meas_valid), .meas_slot(meas_slot),
		.meas_value(meas_value), .meas_status(meas_status),
		.meas_mfr(meas_mfr), .fault_capture(fault_capture),
		.log_clear(log_clear), .rd_start(rd_start), .rd_req(rd_req),
		.rd_data(rd_data), .rd_valid(rd_valid), .rd_busy(rd_busy),
		.buf_locked(buf_locked));
	host_reader host_reader_i (.clock(clock), .rd_start(rd_start),
		.rd_req(rd_req), .rd_data(rd_data), .rd_valid(rd_valid));

	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end
	always @(posedge clock) cyc <= rst ? 0 : cyc + 1;

	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic put(input int s);
		logic [31:0] r;
		int          a;
		r = xs();
		a = wr_rec * 40 + s * 4;
		@(negedge clock);
		meas_valid = 1'b1;
		meas_slot = 4'(s);
		meas_value = r[15:0];
		meas_status = r[23:16];
		meas_mfr = r[31:24];
		@(negedge clock) meas_valid = 1'b0;
		// Frozen while a captured log waits
		if (!locked) begin
			mem[a] = r[7:0];
			mem[a + 1] = r[15:8];
			mem[a + 2] = r[23:16];
			mem[a + 3] = (s == 2 || s == 5) ? 8'h00 : r[31:24];
			if (r[15:0] > pk[s]) pk[s] = r[15:0];
			if (r[15:0] < mn[s]) mn[s] = r[15:0];
			ptr = s * 4 + 3;
			if (s == 9) wr_rec = (wr_rec + 1) % 5;
		end
	endtask

	task automatic pulse_cap();
		@(negedge clock) fault_capture = 1'b1;
		@(negedge clock) fault_capture = 1'b0;
		cap_ptr = ptr;
		cap_rec = wr_rec;
		cap_cyc = cyc;
		locked = 1'b1;
		`CHK("buf_locked", 1'b1, buf_locked)
	endtask

	task automatic check_block(input int gap);
		int          r, p;
		logic [15:0] ts_seen;
		host_reader_i.read_block(gap);
		`CHK("lost bytes", 0, host_reader_i.lost)
		exp_b[0] = BYTE_COUNT;
		exp_b[1] = 8'(cap_ptr);
		for (int s = 0; s < 10; s++) begin
			exp_b[8 + 4 * s] = pk[s][7:0];
			exp_b[9 + 4 * s] = pk[s][15:8];
			exp_b[10 + 4 * s] = mn[s][7:0];
			exp_b[11 + 4 * s] = mn[s][15:8];
		end
		r = cap_rec;
		p = cap_ptr;
		for (int j = 0; j < 191; j++) begin
			exp_b[48 + j] = mem[r * 40 + p];
			if (p == 0) begin
				p = 39;
				r = (r + 4) % 5;
			end else p--;
		end
		for (int j = 239; j < 256; j++) exp_b[j] = 8'h00;
		for (int i = 0; i < 256; i++) begin
			if (i < 2 || i > 7)
				`CHK("block byte", exp_b[i], host_reader_i.got[i])
		end
		// Low 16 bits together; the captured count stays below 256 within the run
		ts_seen = {host_reader_i.got[3], host_reader_i.got[2]};
		ts_seen = ts_seen + 16'h2 - 16'(cap_cyc / 4);
		`CHK("stamp low", 1'b1, ts_seen <= 16'h4)
		for (int i = 4; i < 7; i++)
			`CHK("stamp byte", 8'h00, host_reader_i.got[i])
		`CHK("stamp top", 8'h00, host_reader_i.got[7])
		`CHK("rd_busy", 1'b0, rd_busy)
		`CHK("buf_locked", 1'b0, buf_locked)
		locked = 1'b0;
	endtask

	task test_done();
		if (num_errors == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	initial begin
		#200000;
		num_errors++;
		test_done();
	end

	initial begin
		{rst, meas_valid, fault_capture, log_clear} = 4'hf << 3;
		{meas_slot, meas_value, meas_status, meas_mfr} = '0;
		{wr_rec, ptr, locked} = '0;
		foreach (pk[s]) {pk[s], mn[s]} = {PEAK_RESET, MIN_RESET};
		repeat (2) @(negedge clock);
		rst = 1'b0;
		`CHK("idle busy", 1'b0, rd_busy)
		`CHK("idle lock", 1'b0, buf_locked)
		for (int k = 0; k < 2; k++) begin
			// Fill every record before the pointer wraps round
			for (int i = 0; i < 53 + k * 4; i++) put(i % 10);
			pulse_cap();
			put(3);
			put(9);
			if (k == 1) begin
				@(negedge clock) log_clear = 1'b1;
				@(negedge clock) log_clear = 1'b0;
				locked = 1'b0;
				`CHK("cleared", 1'b0, buf_locked)
				put(1);
				pulse_cap();
			end
			host_reader_i.stray_req(seen);
			`CHK("stray rd_valid", 1'b0, seen)
			check_block(k == 0 ? 1 + int'(xs() % 2) : 0);
		end
		test_done();
	end
endmodule
